// ### rtl/omc_pkg.sv
// Shared constants for the oscillator and operating-mode controller.
// Assumes one system clock and AXI4-Lite register access.
package omc_pkg;

  // Register placement: printed offset is an index, byte address is four times it
  localparam logic [11:0] OSC_MODE_INDEX = 12'h0ca;
  localparam logic [11:0] OSC_MODE_ADDR  = {OSC_MODE_INDEX[9:0], 2'b00};
  localparam logic [7:0]  OSC_MODE_RESET = 8'h00;

  // Field positions of osc_mode_register
  localparam int unsigned HIGH_OSC_STOP_POS = 1;
  localparam int unsigned CLOCK_SELECT_POS  = 2;
  localparam int unsigned MODE_FIELD_LSB    = 3;
  localparam int unsigned MODE_FIELD_MSB    = 4;

  // Processor mode field codes
  localparam logic [1:0] MODE_NORMAL   = 2'h0;
  localparam logic [1:0] MODE_SLEEP    = 2'h1;
  localparam logic [1:0] MODE_GREEN    = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;

  // High-clock option codes
  localparam logic [2:0] OPT_FAST  = 3'h0;
  localparam logic [2:0] OPT_RTC   = 3'h1;
  localparam logic [2:0] OPT_RC    = 3'h2;
  localparam logic [2:0] OPT_X32K  = 3'h3;
  localparam logic [2:0] OPT_X12M  = 3'h4;
  localparam logic [2:0] OPT_X4M   = 3'h5;

  // Warm-up counts in high-speed oscillator clocks, slow divider ratio
  localparam logic [11:0] WARM_RESET_TICKS = 12'h800;
  localparam logic [11:0] WARM_XTAL_TICKS  = 12'h800;
  localparam logic [11:0] WARM_RC_TICKS    = 12'h020;
  localparam int unsigned SLOW_DIV         = 4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_WARMUP,
    ST_RUN,
    ST_SLEEP,
    ST_GREEN
  } omc_state_t;

  // Option uses the internal fast RC
  function automatic logic omc_uses_int_fast(input logic [2:0] opt);
    return (opt == OPT_FAST) || (opt == OPT_RTC);
  endfunction : omc_uses_int_fast

  // Option is an RC-type oscillator (short wake-up)
  function automatic logic omc_is_rc(input logic [2:0] opt);
    return (opt == OPT_FAST) || (opt == OPT_RTC) || (opt == OPT_RC);
  endfunction : omc_is_rc

  // Option runs from a 32 kHz crystal
  function automatic logic omc_is_32k(input logic [2:0] opt);
    return (opt == OPT_RTC) || (opt == OPT_X32K);
  endfunction : omc_is_32k

endpackage : omc_pkg

// ### rtl/omc_tick_div.sv
// Divides a stream of oscillator ticks into one pulse per DIV ticks.
// Assumes tick is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps
module omc_tick_div #(
  parameter int unsigned DIV = omc_pkg::SLOW_DIV
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic tick,
  output logic      pulse_q
);

  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;
  logic          wrap;

  // Wrap on the last tick of a group
  assign wrap = tick && (cnt_q == LAST);

  // Tick counter and output pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q   <= '0;
      pulse_q <= 1'b0;
    end else begin
      if (tick) begin
        cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      end
      pulse_q <= wrap;
    end
  end

  // Helper count of ticks seen since the last pulse
  logic [7:0] seen_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seen_q <= '0;
    end else begin
      seen_q <= pulse_q ? {7'h0, tick} : seen_q + {7'h0, tick};
    end
  end

  div_ratio_a: assert property (@(posedge clk) disable iff (!resetn)
    pulse_q && $past(pulse_q, 1) == 1'b0 && seen_q != 8'h0 |-> seen_q == 8'(DIV))
    else $error("slow pulse not after DIV ticks");

endmodule : omc_tick_div

// ### rtl/omc_top.sv
// Oscillator and operating-mode controller with an AXI4-Lite register slave.
// Assumes oscillator ticks and wake events are one-cycle pulses on clk.
//
// Notes on behaviour
// - Slow mode instruction tick is low RC tick divided by four.
// - Low RC stops only in sleep, or green with 32k option and no watchdog.
// - No separate bit stops the low RC; only mode bits and watchdog do.
// - High-oscillator stop bit 1 halts fast oscillator; low RC continues.
// - Clock-select bit 2: 0 high clock, 1 low RC clock.
// - Mode field bits 4:3: 00 normal, 01 sleep, 10 green, 11 reserved.
// - Stop bit disables whichever oscillator the high-clock option uses.
// - After any reset wait 2048 high clocks before running.
// - Sleep wake waits 2048 clocks for crystals, 32 for RC oscillators.
// - Four modes: normal, slow, power down and green.
// - After reset release the block enters normal mode and runs.
// - Wake from sleep always returns to normal mode.
// - Green entered from normal wakes to normal.
// - Normal mode keeps high oscillator and low RC running.
// - Low RC clocks the watchdog and slow-mode system clock.
// - Second timer keeps running in green under its enable.
// - Waking clears the matching processor mode bit.
// - Green entered from slow wakes to slow.
// - Port change wakes both sleeps; first timer overflow wakes green.
// - Slow mode alone does not stop the high oscillator.
`timescale 1ns/1ps
module omc_top #(
  parameter logic [11:0] WARM_RESET = omc_pkg::WARM_RESET_TICKS,
  parameter logic [11:0] WARM_XTAL  = omc_pkg::WARM_XTAL_TICKS,
  parameter logic [11:0] WARM_RC    = omc_pkg::WARM_RC_TICKS
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [2:0]  high_clk_option,
  input  wire logic        watchdog_enable,
  input  wire logic        high_osc_tick,
  input  wire logic        low_rc_tick,
  input  wire logic        port_wake,
  input  wire logic        first_timer_overflow,
  input  wire logic        first_timer_enable,
  input  wire logic        second_timer_enable,
  input  wire logic        buzzer_enable,
  output logic             internal_high_rc_en,
  output logic             crystal_32k_en,
  output logic             external_high_osc_en,
  output logic             internal_low_rc_en,
  output logic             watchdog_tick,
  output logic             sys_clk_low,
  output logic             cpu_tick,
  output logic             cpu_run,
  output logic             first_timer_run,
  output logic             second_timer_run,
  output logic             buzzer_run
);

  // Sequences and checks share one clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  omc_pkg::omc_state_t state_q;
  omc_pkg::omc_state_t state_d;
  logic       hostop_q;
  logic       clksel_q;
  logic [1:0] mode_q;
  logic       hostop_d;
  logic       clksel_d;
  logic [1:0] mode_d;

  // Bus slave state
  logic wr_go;
  logic rd_go;
  logic wr_hit;
  logic wr_ok;
  logic rd_hit;
  logic [31:0] reg_word;

  // Mode and oscillator decode
  logic        wake_sleep;
  logic        wake_green;
  logic        high_on;
  logic        opt_fast;
  logic        warm_done;
  logic        slow_pulse;
  logic [11:0] wake_target;
  logic        mode_is_sleep;
  logic        mode_is_green;
  logic        low_rc_on;

  // Write taken when address and data meet the raised readies
  assign wr_go  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_go  = s_axi_arvalid && s_axi_arready;
  assign wr_hit = (s_axi_awaddr[11:2] == omc_pkg::OSC_MODE_ADDR[11:2]);
  assign wr_ok  = wr_go && wr_hit && s_axi_wstrb[0];
  assign rd_hit = (s_axi_araddr[11:2] == omc_pkg::OSC_MODE_ADDR[11:2]);

  // Register image, unused bits zero
  assign reg_word = {27'h0, mode_q, clksel_q, hostop_q, 1'b0};

  // Write channel: readies raised together once both halves are offered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= omc_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? omc_pkg::RESP_OKAY : omc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read in flight
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= omc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_hit ? reg_word : 32'h0;
        s_axi_rresp  <= rd_hit ? omc_pkg::RESP_OKAY : omc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Wake events per mode
  assign wake_sleep = (state_q == omc_pkg::ST_SLEEP) && port_wake;
  assign wake_green = (state_q == omc_pkg::ST_GREEN)
                      && (port_wake || first_timer_overflow);

  // Register next values; wake clearing beats a same-cycle write
  assign hostop_d = wr_ok ? s_axi_wdata[omc_pkg::HIGH_OSC_STOP_POS] : hostop_q;
  assign clksel_d = wake_sleep ? 1'b0
                  : wr_ok ? s_axi_wdata[omc_pkg::CLOCK_SELECT_POS] : clksel_q;
  assign mode_d = (wake_sleep || wake_green) ? omc_pkg::MODE_NORMAL
                : (wr_ok && state_q == omc_pkg::ST_RUN)
                  ? s_axi_wdata[omc_pkg::MODE_FIELD_MSB:omc_pkg::MODE_FIELD_LSB]
                  : mode_q;

  // Mode register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hostop_q <= omc_pkg::OSC_MODE_RESET[omc_pkg::HIGH_OSC_STOP_POS];
      clksel_q <= omc_pkg::OSC_MODE_RESET[omc_pkg::CLOCK_SELECT_POS];
      mode_q   <= omc_pkg::OSC_MODE_RESET[omc_pkg::MODE_FIELD_MSB:omc_pkg::MODE_FIELD_LSB];
    end else begin
      hostop_q <= hostop_d;
      clksel_q <= clksel_d;
      mode_q   <= mode_d;
    end
  end

  // Mode field decode; reserved code behaves as normal
  assign mode_is_sleep = (mode_q == omc_pkg::MODE_SLEEP);
  assign mode_is_green = (mode_q == omc_pkg::MODE_GREEN);

  // Operating-mode sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      omc_pkg::ST_WARMUP: begin
        if (warm_done) begin
          state_d = omc_pkg::ST_RUN;
        end
      end
      omc_pkg::ST_RUN: begin
        if (mode_is_sleep) begin
          state_d = omc_pkg::ST_SLEEP;
        end else if (mode_is_green) begin
          state_d = omc_pkg::ST_GREEN;
        end
      end
      omc_pkg::ST_SLEEP: begin
        if (wake_sleep) begin
          state_d = omc_pkg::ST_WARMUP;
        end
      end
      omc_pkg::ST_GREEN: begin
        if (wake_green) begin
          state_d = omc_pkg::ST_RUN;
        end
      end
      default: state_d = omc_pkg::ST_WARMUP;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= omc_pkg::ST_WARMUP;
    end else begin
      state_q <= state_d;
    end
  end

  // Wake-up warm-up length by oscillator type
  assign wake_target = omc_pkg::omc_is_rc(high_clk_option) ? WARM_RC : WARM_XTAL;

  omc_warmup #(
    .RESET_TGT (WARM_RESET)
  ) omc_warmup_i (
    .clk    (clk),
    .resetn (resetn),
    .start  (wake_sleep),
    .target (wake_target),
    .tick   (high_osc_tick),
    .done_q (warm_done)
  );

  // Oscillator enables; slow mode alone never stops the fast oscillator
  assign opt_fast  = omc_pkg::omc_uses_int_fast(high_clk_option);
  assign high_on   = (state_q == omc_pkg::ST_WARMUP)
                     || ((state_q == omc_pkg::ST_RUN || state_q == omc_pkg::ST_GREEN)
                         && !hostop_q);
  // Only the mode and the watchdog setting may stop the low RC
  assign low_rc_on = (state_q != omc_pkg::ST_SLEEP)
                     && !((state_q == omc_pkg::ST_GREEN)
                          && omc_pkg::omc_is_32k(high_clk_option)
                          && !watchdog_enable);

  omc_tick_div #(
    .DIV (omc_pkg::SLOW_DIV)
  ) omc_tick_div_i (
    .clk     (clk),
    .resetn  (resetn),
    .tick    (low_rc_tick && internal_low_rc_en),
    .pulse_q (slow_pulse)
  );

  // Registered oscillator, clock and timer outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      internal_high_rc_en  <= 1'b0;
      crystal_32k_en       <= 1'b0;
      external_high_osc_en <= 1'b0;
      internal_low_rc_en   <= 1'b0;
      watchdog_tick        <= 1'b0;
      sys_clk_low          <= 1'b0;
      cpu_tick             <= 1'b0;
      cpu_run              <= 1'b0;
      first_timer_run      <= 1'b0;
      second_timer_run     <= 1'b0;
      buzzer_run           <= 1'b0;
    end else begin
      internal_high_rc_en  <= opt_fast && high_on
                              && !(state_q == omc_pkg::ST_GREEN
                                   && high_clk_option == omc_pkg::OPT_RTC);
      crystal_32k_en       <= (high_clk_option == omc_pkg::OPT_RTC)
                              && (high_on || state_q == omc_pkg::ST_GREEN);
      external_high_osc_en <= !opt_fast && high_on;
      internal_low_rc_en   <= low_rc_on;
      watchdog_tick        <= low_rc_tick && internal_low_rc_en;
      sys_clk_low          <= clksel_q;
      cpu_tick             <= (state_q == omc_pkg::ST_RUN)
                              && (clksel_q ? slow_pulse
                                           : (high_osc_tick && high_on));
      cpu_run              <= (state_q == omc_pkg::ST_RUN);
      first_timer_run      <= first_timer_enable && (state_q != omc_pkg::ST_SLEEP);
      second_timer_run     <= second_timer_enable && (state_q != omc_pkg::ST_SLEEP);
      buzzer_run           <= buzzer_enable && (state_q != omc_pkg::ST_SLEEP);
    end
  end

  // Single-cycle wake event sequences
  sequence s_sleep_wake;
    (state_q == omc_pkg::ST_SLEEP) && port_wake;
  endsequence
  sequence s_green_wake;
    (state_q == omc_pkg::ST_GREEN) && (port_wake || first_timer_overflow);
  endsequence

  low_rc_stop_a: assert property ($fell(internal_low_rc_en) |->
    $past(state_q, 1) == omc_pkg::ST_SLEEP || $past(state_q, 1) == omc_pkg::ST_GREEN)
    else $error("low RC stopped outside sleep or green");
  high_stop_a: assert property ((state_q == omc_pkg::ST_RUN) && hostop_q
    |=> !internal_high_rc_en && !external_high_osc_en)
    else $error("fast oscillator runs with stop bit set");
  slow_keep_a: assert property ((state_q == omc_pkg::ST_RUN) && clksel_q && !hostop_q
    && !opt_fast |=> external_high_osc_en)
    else $error("slow mode stopped the fast oscillator");
  sleep_enter_a: assert property ((state_q == omc_pkg::ST_RUN) && mode_is_sleep
    |=> (state_q == omc_pkg::ST_SLEEP) ##1 !cpu_run && !internal_low_rc_en)
    else $error("sleep code did not power down");
  run_gate_a: assert property ((state_q == omc_pkg::ST_WARMUP)
    |=> !cpu_run && !cpu_tick)
    else $error("cpu ran during warm-up");
  sleep_wake_a: assert property (s_sleep_wake |=>
    (state_q == omc_pkg::ST_WARMUP) && !clksel_q && (mode_q == omc_pkg::MODE_NORMAL))
    else $error("sleep wake did not return to normal");
  green_wake_a: assert property (s_green_wake |=>
    (state_q == omc_pkg::ST_RUN) && clksel_q == $past(clksel_q, 1) && mode_q == 2'h0)
    else $error("green wake lost the previous clock mode");
  green_timer_a: assert property ((state_q == omc_pkg::ST_GREEN) && second_timer_enable
    |=> second_timer_run)
    else $error("second timer stopped in green mode");
  rsvd_mode_a: assert property ((state_q == omc_pkg::ST_RUN)
    && (mode_q == omc_pkg::MODE_RESERVED) |=> state_q == omc_pkg::ST_RUN)
    else $error("reserved mode code left normal run");

endmodule : omc_top

// ### rtl/omc_warmup.sv
// Warm-up counter of high-speed oscillator clocks.
// Assumes tick is a one-cycle pulse per oscillator clock; starts loaded after reset.
`timescale 1ns/1ps
module omc_warmup #(
  parameter logic [11:0] RESET_TGT = omc_pkg::WARM_RESET_TICKS
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic [11:0] target,
  input  wire logic        tick,
  output logic             done_q
);

  logic [11:0] cnt_q;
  logic [11:0] tgt_q;
  logic [11:0] cnt_inc;

  assign cnt_inc = cnt_q + 12'h001;

  // Count ticks until the target is reached
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q  <= '0;
      tgt_q  <= RESET_TGT;
      done_q <= 1'b0;
    end else if (start) begin
      cnt_q  <= '0;
      tgt_q  <= target;
      done_q <= 1'b0;
    end else if (tick && !done_q) begin
      cnt_q  <= cnt_inc;
      done_q <= (cnt_inc == tgt_q);
    end
  end

  warm_count_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(done_q) |-> cnt_q == tgt_q)
    else $error("warm-up ended before the target count");

endmodule : omc_warmup

// ### verif/omc_partner.sv
// Oscillator model on the far side: makes tick pulses only while enabled.
// Assumes enables are registered levels from the controller on clk.
`timescale 1ns/1ps
module omc_partner #(
  parameter int HI_PER = 4,
  parameter int LO_PER = 7
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic hi_en,
  input  wire logic lo_en,
  output logic      hi_tick,
  output logic      lo_tick
);
  logic [3:0] hi_q;
  logic [3:0] lo_q;

  // A stopped oscillator loses its phase and starts over when enabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_q    <= 4'h0;
      lo_q    <= 4'h0;
      hi_tick <= 1'b0;
      lo_tick <= 1'b0;
    end else begin
      hi_q    <= (!hi_en || hi_q == 4'(HI_PER - 1)) ? 4'h0 : hi_q + 4'h1;
      lo_q    <= (!lo_en || lo_q == 4'(LO_PER - 1)) ? 4'h0 : lo_q + 4'h1;
      hi_tick <= hi_en && hi_q == 4'(HI_PER - 1);
      lo_tick <= lo_en && lo_q == 4'(LO_PER - 1);
    end
  end
endmodule : omc_partner

// ### verif/omc_top_bench.sv
// Self-checking bench for the oscillator and mode controller.
// Assumes the oscillator model of omc_partner and shortened warm-up counts.
`timescale 1ns/1ps
module omc_top_bench;
  localparam int          W_RST = 8;
  localparam int          W_XT  = 8;
  localparam int          W_RC  = 4;
  localparam logic [11:0] ra    = omc_pkg::OSC_MODE_ADDR;
  localparam logic [1:0]  ok    = omc_pkg::RESP_OKAY;
  localparam logic [1:0]  err   = omc_pkg::RESP_SLVERR;
  logic clk = 1'b0, resetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  high_clk_option = 3'h0;
  logic watchdog_enable = 1'b1, port_wake = 1'b0, first_timer_overflow = 1'b0;
  logic first_timer_enable = 1'b1, second_timer_enable = 1'b1, buzzer_enable = 1'b1;
  logic high_osc_tick, low_rc_tick, internal_high_rc_en, crystal_32k_en;
  logic external_high_osc_en, internal_low_rc_en, watchdog_tick, sys_clk_low;
  logic cpu_tick, cpu_run, first_timer_run, second_timer_run, buzzer_run;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          bad_count = 0, cmp_count = 0, cyc = 0, t, w;
  logic [31:0] d;
  logic [33:0] e;

  always #12.5 clk = ~clk;

  omc_top #(.WARM_RESET(12'(W_RST)), .WARM_XTAL(12'(W_XT)), .WARM_RC(12'(W_RC))) omc_top_i (
    .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_clk_option, .watchdog_enable,
    .high_osc_tick, .low_rc_tick, .port_wake, .first_timer_overflow,
    .first_timer_enable, .second_timer_enable, .buzzer_enable, .internal_high_rc_en,
    .crystal_32k_en, .external_high_osc_en, .internal_low_rc_en, .watchdog_tick,
    .sys_clk_low, .cpu_tick, .cpu_run, .first_timer_run, .second_timer_run, .buzzer_run);

  omc_partner omc_partner_i (
    .clk(clk), .resetn(resetn), .hi_en(internal_high_rc_en | external_high_osc_en),
    .lo_en(internal_low_rc_en), .hi_tick(high_osc_tick), .lo_tick(low_rc_tick));

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  // Scoreboard: each bus answer is paired with the oldest note
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
      check("bresp", 32'(s_axi_bresp), 32'(bq.pop_front()));
    end
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
      e = rq.pop_front();
      check("rresp", 32'(s_axi_rresp), 32'(e[33:32]));
      check("rdata", s_axi_rdata, e[31:0]);
    end
  end

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                        input logic [1:0] r);
    @(posedge clk);
    bq.push_back(r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge clk);
    rq.push_back({r, v});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // Counts oscillator ticks until execution resumes
  task automatic run_wait(output int n);
    n = 0;
    do begin
      @(posedge clk);
      if (high_osc_tick) n++;
    end while (cpu_run !== 1'b1);
  endtask : run_wait

  // Source ticks and watchdog ticks between two instruction ticks
  task automatic gap(input logic lo, output int n, output int wd);
    n = 0;
    wd = 0;
    do @(posedge clk); while (cpu_tick !== 1'b1);
    do begin
      @(posedge clk);
      if (lo ? low_rc_tick : high_osc_tick) n++;
      if (watchdog_tick === 1'b1) wd++;
    end while (cpu_tick !== 1'b1);
  endtask : gap

  // One-cycle wake pulse: port change or first timer overflow
  task automatic wake(input logic p);
    @(posedge clk);
    port_wake <= p;
    first_timer_overflow <= !p;
    @(posedge clk);
    port_wake <= 1'b0;
    first_timer_overflow <= 1'b0;
  endtask : wake

  // Main sequence
  initial begin
    void'($urandom(32'ha211bd5a));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    run_wait(t);
    check("warm_reset", t, W_RST);
    check("normal_osc", 32'({internal_high_rc_en, internal_low_rc_en}), 32'h3);
    axi_rd(ra, 32'h0, ok);
    for (int o = 0; o < 6; o++) begin
      high_clk_option <= 3'(o);
      axi_wr(ra, 32'h08, 4'hf, ok);
      repeat (4) @(posedge clk);
      wake(1'b0);
      repeat (3) @(posedge clk);
      check("sleep_out", 32'({internal_high_rc_en, external_high_osc_en, internal_low_rc_en,
                              crystal_32k_en, cpu_run, first_timer_run, second_timer_run,
                              buzzer_run}), 32'h0);
      wake(1'b1);
      run_wait(t);
      check("warm_wake", t, o < 3 ? W_RC : W_XT);
      check("int_fast_en", internal_high_rc_en, o < 2);
      check("ext_en", external_high_osc_en, o >= 2);
      check("crystal_en", crystal_32k_en, o == 1);
      axi_rd(ra, 32'h0, ok);
    end
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      axi_wr(ra, d & 32'hffffffe7, 4'hf, ok);
      axi_rd(ra, d & 32'h6, ok);
    end
    axi_wr(ra, 32'h18, 4'hf, ok);
    repeat (4) @(posedge clk);
    check("reserved_run", cpu_run, 1'b1);
    axi_rd(ra, 32'h18, ok);
    axi_wr(ra, 32'h0, 4'hf, ok);
    axi_wr(12'h32c, 32'h4, 4'hf, err);
    axi_rd(12'h000, 32'h0, err);
    axi_wr(ra, 32'h4, 4'he, ok);
    axi_rd(ra, 32'h0, ok);
    axi_wr(ra, 32'h4, 4'hf, ok);
    repeat (3) @(posedge clk);
    check("slow_sel", 32'({sys_clk_low, external_high_osc_en}), 32'h3);
    gap(1'b1, t, w);
    check("slow_div", t, 4);
    check("wdog_ticks", w, 4);
    axi_wr(ra, 32'h6, 4'hf, ok);
    repeat (3) @(posedge clk);
    check("stop_osc", 32'({external_high_osc_en, internal_low_rc_en}),
          32'h1);
    d = $urandom;
    {first_timer_enable, second_timer_enable, buzzer_enable} <= d[2:0];
    axi_wr(ra, 32'h16, 4'hf, ok);
    repeat (4) @(posedge clk);
    check("green_out", 32'({cpu_run, second_timer_run, buzzer_run, first_timer_run,
                            internal_low_rc_en}),
          32'({1'b0, d[1], d[0], d[2], 1'b1}));
    wake(1'b0);
    run_wait(t);
    axi_rd(ra, 32'h6, ok);
    high_clk_option <= 3'h3;
    watchdog_enable <= 1'b0;
    {first_timer_enable, second_timer_enable, buzzer_enable} <= 3'h7;
    axi_wr(ra, 32'h0, 4'hf, ok);
    axi_wr(ra, 32'h10, 4'hf, ok);
    repeat (4) @(posedge clk);
    check("green_32k_lo", internal_low_rc_en, 1'b0);
    wake(1'b1);
    run_wait(t);
    axi_rd(ra, 32'h0, ok);
    check("normal_lo", internal_low_rc_en, 1'b1);
    final_report();
  end
endmodule : omc_top_bench
